// ===== iac_pkg.sv
// Purpose: shared constants and types of the i2c addressing and data/command block
// Assumes: 32-bit avalon-mm byte addresses, registers one aligned word each
// Notes: register fields sit in the low 16 bits, upper bits read as zero
package iac_pkg;
   // register byte addresses
   localparam logic [31:0] OFS_CONTROL = 32'h5000_1300;
   localparam logic [31:0] OFS_TARGET = 32'h5000_1304;
   localparam logic [31:0] OFS_OWN = 32'h5000_1308;
   localparam logic [31:0] OFS_DATA = 32'h5000_1310;
   localparam logic [31:0] OFS_ENABLE = 32'h5000_1380;
   localparam logic [31:0] OFS_STATUS = 32'h5000_1384;
   // field positions
   localparam int CON_MWIDE_BIT = 4;
   localparam int CON_SWIDE_BIT = 3;
   localparam int TAR_SPECIAL_BIT = 11;
   localparam int TAR_CHOICE_BIT = 10;
   localparam int DATA_CMD_BIT = 8;
   localparam int ENABLE_BIT = 0;
   localparam int STAT_ABORT_BIT = 6;
   localparam int STAT_RDREQ_BIT = 5;
   localparam int STAT_GCMODE_BIT = 4;
   // reset values
   localparam logic [11:0] TAR_RESET = 12'h055;
   localparam logic [9:0] SAR_RESET = 10'h055;
   localparam logic CON_MWIDE_RESET = 1'b1;
   localparam logic CON_SWIDE_RESET = 1'b1;
   // special address bytes on the wire
   localparam logic [7:0] GC_ADDR_BYTE = 8'h00;
   localparam logic [7:0] START_BYTE_VALUE = 8'h01;
   localparam logic [4:0] WIDE_PREFIX = 5'h1E;
   // bit counter limits of the byte receiver
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   // slave address matcher states
   typedef enum logic [3:0] {
      slv_idle = 4'h1,
      slv_first = 4'h2,
      slv_second = 4'h4,
      slv_hold = 4'h8
   } iac_slv_state_t;
endpackage

// ===== iac_sync.sv
// Purpose: two-flop synchroniser for pins entering the core clock domain
// Assumes: inputs are asynchronous levels
// Notes: the first stage is read only by the second
`timescale 1ns/100ps
module iac_sync #(
   parameter int WIDTH = 2
) (
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } iac_sync_state_t;
   iac_sync_state_t s;
   iac_sync_state_t next_s;

   // reset high: released i2c lines idle high
   always_comb begin
      next_s.stage1 = i_async;
      next_s.stage2 = s.stage1;
   end

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         s <= '1;
      end else begin
         s <= next_s;
      end
   end

   assign o_sync = s.stage2;
endmodule

// ===== iac_byte_rx.sv
// Purpose: watches synchronised scl/sda, reports start, stop, scl falls and whole bytes
// Assumes: inputs already synchronised to i_clock
// Notes: the ninth (acknowledge) clock is counted but not shifted
`timescale 1ns/100ps
module iac_byte_rx
   import iac_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_start,
   output logic o_stop,
   output logic o_fall,
   output logic o_byte_done,
   output logic [7:0] o_byte
);
   typedef struct packed {
      logic scl_d;
      logic sda_d;
      logic [7:0] bits;
      logic [3:0] count;
      logic start;
      logic stop;
      logic fall;
      logic done;
   } iac_rx_state_t;
   iac_rx_state_t s;
   iac_rx_state_t next_s;

   // edge detection and bit shifting, msb first
   always_comb begin
      next_s = s;
      next_s.scl_d = i_scl;
      next_s.sda_d = i_sda;
      next_s.start = s.scl_d && i_scl && s.sda_d && !i_sda;
      next_s.stop = s.scl_d && i_scl && !s.sda_d && i_sda;
      next_s.fall = s.scl_d && !i_scl;
      next_s.done = 1'b0;
      if (next_s.start || next_s.stop) begin
         next_s.count = 4'h0;
      end else if (!s.scl_d && i_scl) begin
         if (s.count == BITS_PER_BYTE) begin
            next_s.count = 4'h0;
         end else begin
            next_s.bits = {s.bits[6:0], i_sda};
            next_s.count = s.count + 4'h1;
            next_s.done = (s.count == BITS_PER_BYTE - 4'h1);
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         s <= '0;
         s.scl_d <= 1'b1;
         s.sda_d <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign o_start = s.start;
   assign o_stop = s.stop;
   assign o_fall = s.fall;
   assign o_byte_done = s.done;
   assign o_byte = s.bits;
endmodule

// ===== iac_top.sv
// Purpose: i2c target/own address registers, data/command port, address matching
// Assumes: avalon-mm slave on i_clock; scl/sda pins are asynchronous
// Notes: transmit fifo and bus engine sit outside; this block feeds and reports
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/100ps
module iac_top
   import iac_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic [31:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic o_tx_valid,
   output logic [8:0] o_tx_data,
   input wire logic i_tx_ready,
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_byte,
   output logic o_rx_pop,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe,
   output logic [7:0] o_addr_first,
   output logic [7:0] o_addr_second,
   output logic o_addr_two,
   output logic o_interface_enable,
   output logic o_transmit_abort,
   output logic o_read_request
);
   typedef struct packed {
      logic waitreq;
      logic [31:0] rdata;
      logic mwide;
      logic swide;
      logic [11:0] tar;
      logic [9:0] sar;
      logic enable;
      logic abort;
      logic rd_req;
      logic gc_mode;
      logic tx_valid;
      logic [8:0] tx_data;
      logic rx_pop;
      iac_slv_state_t slv;
      logic wide_hit;
      logic [1:0] ack_phase;
      logic sda_oe;
      logic [7:0] addr_first;
      logic [7:0] addr_second;
      logic addr_two;
   } iac_state_t;
   iac_state_t s;
   iac_state_t next_s;

   logic [1:0] pins_sync;
   logic rx_start;
   logic rx_stop;
   logic rx_fall;
   logic rx_done;
   logic [7:0] rx_byte;
   logic bus_take;
   logic data_take;
   logic tar_wr;
   logic cmd_read;
   logic rd_cmd_take;
   logic self_target;
   logic abort_evt;
   logic rdreq_evt;
   logic rdreq_clr;
   logic match;
   logic [15:0] word16;

   iac_sync #(
      .WIDTH(2)
   ) u_sync (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_async({i_scl, i_sda}),
      .o_sync(pins_sync)
   );

   iac_byte_rx u_rx (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_scl(pins_sync[1]),
      .i_sda(pins_sync[0]),
      .o_start(rx_start),
      .o_stop(rx_stop),
      .o_fall(rx_fall),
      .o_byte_done(rx_done),
      .o_byte(rx_byte)
   );

   // merge a 16-bit register with the enabled write lanes
   function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
      lane_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   // request qualifiers; a request is answered once, in the cycle waitrequest is low
   assign bus_take = (i_avs_read || i_avs_write) && s.waitreq;
   assign tar_wr = bus_take && i_avs_write && (i_avs_address == OFS_TARGET);
   // a data write stalls while the queued entry has not been taken
   assign data_take = bus_take && i_avs_write && (i_avs_address == OFS_DATA)
                      && (!s.tx_valid || i_tx_ready);
   assign cmd_read = i_avs_writedata[DATA_CMD_BIT];
   assign rd_cmd_take = data_take && cmd_read;
   assign self_target = s.mwide ? (s.tar[9:0] == s.sar) : (s.tar[6:0] == s.sar[6:0]);

   // register file, command queueing and slave address matching
   always_comb begin
      next_s = s;
      abort_evt = 1'b0;
      rdreq_evt = 1'b0;
      rdreq_clr = 1'b0;
      match = 1'b0;
      word16 = 16'h0000;
      next_s.waitreq = 1'b1;
      next_s.rx_pop = 1'b0;
      if (s.tx_valid && i_tx_ready) begin
         next_s.tx_valid = 1'b0;
      end
      // unmapped addresses answer at once: reads give zero, writes do nothing
      if (bus_take && i_avs_write) begin
         next_s.waitreq = 1'b0;
         case (i_avs_address)
            OFS_CONTROL: begin
               word16 = lane_merge({11'h000, s.mwide, s.swide, 3'h0}, i_avs_writedata,
                                   i_avs_byteenable);
               next_s.mwide = word16[CON_MWIDE_BIT];
               next_s.swide = word16[CON_SWIDE_BIT];
            end
            OFS_TARGET: begin
               word16 = lane_merge({4'h0, s.tar}, i_avs_writedata, i_avs_byteenable);
               next_s.tar = word16[11:0];
            end
            OFS_OWN: begin
               word16 = lane_merge({6'h00, s.sar}, i_avs_writedata, i_avs_byteenable);
               if (!s.enable) begin
                  next_s.sar = word16[9:0];
               end
            end
            OFS_DATA: begin
               // the port stalls until the previous entry is gone
               next_s.waitreq = !data_take;
               if (data_take) begin
                  // write commands here, read commands after the matcher
                  if (!cmd_read) begin
                     // one entry per write, slave transmit byte
                     next_s.tx_valid = 1'b1;
                     next_s.tx_data = {1'b0, i_avs_writedata[7:0]};
                     rdreq_clr = s.rd_req;
                  end
               end
            end
            OFS_ENABLE: begin
               if (i_avs_byteenable[0]) begin
                  next_s.enable = i_avs_writedata[ENABLE_BIT];
               end
            end
            OFS_STATUS: begin
               // write one to clear the sticky abort
               if (i_avs_byteenable[0] && i_avs_writedata[STAT_ABORT_BIT]) begin
                  next_s.abort = 1'b0;
               end
            end
            default: begin
               next_s.waitreq = 1'b0;
            end
         endcase
      end else if (bus_take && i_avs_read) begin
         next_s.waitreq = 1'b0;
         case (i_avs_address)
            OFS_CONTROL: next_s.rdata = {27'h000_0000, s.mwide, s.swide, 3'h0};
            OFS_TARGET: next_s.rdata = {20'h0_0000, s.tar};
            OFS_OWN: next_s.rdata = {22'h00_0000, s.sar};
            OFS_DATA: begin
               // received byte, consumed by the read
               next_s.rdata = {24'h00_0000, i_rx_byte};
               next_s.rx_pop = i_rx_valid;
            end
            OFS_ENABLE: next_s.rdata = {31'h0000_0000, s.enable};
            OFS_STATUS: next_s.rdata = {25'h000_0000, s.abort, s.rd_req, s.gc_mode, 4'h0};
            default: next_s.rdata = 32'h0000_0000;
         endcase
      end

      // general call mode follows the special bit while the choice bit is clear
      next_s.gc_mode = next_s.tar[TAR_SPECIAL_BIT] && !next_s.tar[TAR_CHOICE_BIT];

      // slave address matcher; acknowledge drives sda low for the ninth clock
      if (rx_fall && s.ack_phase == 2'h1) begin
         next_s.sda_oe = 1'b1;
         next_s.ack_phase = 2'h2;
      end else if (rx_fall && s.ack_phase == 2'h2) begin
         next_s.sda_oe = 1'b0;
         next_s.ack_phase = 2'h0;
      end
      if (!s.enable) begin
         next_s.slv = slv_idle;
         next_s.wide_hit = 1'b0;
         next_s.sda_oe = 1'b0;
         next_s.ack_phase = 2'h0;
      end else if (rx_stop) begin
         next_s.slv = slv_idle;
         next_s.wide_hit = 1'b0;
      end else if (rx_start) begin
         next_s.slv = slv_first;
      end else if (rx_done) begin
         case (s.slv)
            slv_first: begin
               // matching width chosen by control bit
               if (s.swide) begin
                  // ten-bit header carries the two top bits
                  if (rx_byte[7:3] == WIDE_PREFIX && rx_byte[2:1] == s.sar[9:8]) begin
                     if (!rx_byte[0]) begin
                        match = 1'b1;
                        next_s.slv = slv_second;
                     end else if (s.wide_hit) begin
                        match = 1'b1;
                        rdreq_evt = 1'b1;
                        next_s.slv = slv_hold;
                     end else begin
                        next_s.slv = slv_hold;
                     end
                  end else begin
                     next_s.slv = slv_hold;
                  end
               end else begin
                  // seven-bit matching uses the low bits only
                  match = (rx_byte[7:1] == s.sar[6:0]);
                  rdreq_evt = match && rx_byte[0];
                  next_s.slv = slv_hold;
               end
            end
            slv_second: begin
               match = (rx_byte == s.sar[7:0]);
               next_s.wide_hit = match;
               next_s.slv = slv_hold;
            end
            default: next_s.slv = s.slv;
         endcase
         if (match) begin
            next_s.ack_phase = 2'h1;
         end
      end

      // a same-cycle read request also refuses
      if (rd_cmd_take) begin
         if (s.gc_mode || s.rd_req || rdreq_evt || self_target) begin
            abort_evt = 1'b1;
         end else begin
            // byte of a read command is ignored
            next_s.tx_valid = 1'b1;
            next_s.tx_data = {1'b1, 8'h00};
         end
      end

      // sticky flags: a new event wins over a clear in the same cycle
      next_s.abort = next_s.abort || abort_evt;
      next_s.rd_req = (s.rd_req && !rdreq_clr) || rdreq_evt;

      // master address bytes for the head entry
      if (s.tar[TAR_SPECIAL_BIT]) begin
         next_s.addr_first = s.tar[TAR_CHOICE_BIT] ? START_BYTE_VALUE : GC_ADDR_BYTE;
         next_s.addr_second = 8'h00;
         next_s.addr_two = 1'b0;
      end else if (s.mwide) begin
         next_s.addr_first = {WIDE_PREFIX, s.tar[9:8], s.tx_data[DATA_CMD_BIT]};
         next_s.addr_second = s.tar[7:0];
         next_s.addr_two = 1'b1;
      end else begin
         next_s.addr_first = {s.tar[6:0], s.tx_data[DATA_CMD_BIT]};
         next_s.addr_second = 8'h00;
         next_s.addr_two = 1'b0;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         s <= '0;
         s.waitreq <= 1'b1;
         s.mwide <= CON_MWIDE_RESET;
         s.swide <= CON_SWIDE_RESET;
         s.tar <= TAR_RESET;
         s.sar <= SAR_RESET;
         s.slv <= slv_idle;
      end else begin
         s <= next_s;
      end
   end

   // every output except the constant o_sda comes from the state register
   assign o_avs_readdata = s.rdata;
   assign o_avs_waitrequest = s.waitreq;
   assign o_tx_valid = s.tx_valid;
   assign o_tx_data = s.tx_data;
   assign o_rx_pop = s.rx_pop;
   assign o_sda = 1'b0; // open drain: only the enable ever changes
   assign o_sda_oe = s.sda_oe;
   assign o_addr_first = s.addr_first;
   assign o_addr_second = s.addr_second;
   assign o_addr_two = s.addr_two;
   assign o_interface_enable = s.enable;
   assign o_transmit_abort = s.abort;
   assign o_read_request = s.rd_req;

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_resetn);

   chk_sar_locked: assert property (
      s.enable && bus_take && i_avs_write && i_avs_address == OFS_OWN |=> $stable(s.sar))
      else $error("own address changed while enabled");
   chk_gc_read_abort: assert property (
      data_take && cmd_read && s.gc_mode |=> s.abort && !s.tx_valid && !s.waitreq)
      else $error("read after general call not aborted");
   chk_rdreq_abort: assert property (
      data_take && cmd_read && s.rd_req |=> s.abort ##0 !s.tx_valid)
      else $error("read command during read request not aborted");
   chk_push_entry: assert property (
      data_take && !cmd_read |=> s.tx_valid && s.tx_data == {1'b0, $past(i_avs_writedata[7:0])})
      else $error("write command not queued");
   chk_gc_address: assert property (
      s.tar[TAR_SPECIAL_BIT] && !s.tar[TAR_CHOICE_BIT] |=> o_addr_first == GC_ADDR_BYTE && !o_addr_two)
      else $error("general call address wrong");
   chk_start_byte: assert property (
      s.tar[TAR_SPECIAL_BIT] && s.tar[TAR_CHOICE_BIT] |=> o_addr_first == START_BYTE_VALUE)
      else $error("start byte wrong");
   chk_wide_master: assert property (
      !s.tar[TAR_SPECIAL_BIT] && s.mwide |=> o_addr_two && o_addr_first[7:3] == WIDE_PREFIX
         && o_addr_second == $past(s.tar[7:0]))
      else $error("ten-bit master address wrong");
   chk_gc_sticky: assert property (
      s.gc_mode && !tar_wr |=> s.gc_mode ##0 (tar_wr or ##1 s.gc_mode))
      else $error("general call mode left without clearing");
   chk_slave_match: assert property (
      s.enable && !s.swide && s.slv == slv_first && rx_done && !rx_stop && !rx_start
         && rx_byte[7:1] == s.sar[6:0] && rx_byte[0] |=> s.rd_req && s.ack_phase == 2'h1)
      else $error("own seven-bit address not matched");
   chk_read_data: assert property (
      bus_take && i_avs_read && i_avs_address == OFS_DATA
         |=> !o_avs_waitrequest && o_avs_readdata == {24'h00_0000, $past(i_rx_byte)})
      else $error("data port read wrong");
endmodule

// ===== iac_link_model.sv
// Purpose: behavioural i2c master on the far side of the slave link
// Assumes: sda open drain with a pull-up, scl period 80 ns
// Notes: scl stands high between frames, no clock runs outside them
`timescale 1ns/100ps
module iac_link_model (
   input wire logic i_sda_oe,
   output logic o_scl,
   output logic o_sda
);
   logic rel;
   // wired-and of both drivers; a released line is pulled up
   assign o_sda = rel & !i_sda_oe;
   // bus idle at time zero
   initial begin
      o_scl = 1'b1;
      rel = 1'b1;
   end
   // start, one byte msb first, acknowledge clock, stop
   task automatic frame(input logic [7:0] b, output logic ack);
      rel = 1'b0;
      #40 o_scl = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         #10 rel = b[i];
         #30 o_scl = 1'b1;
         #40 o_scl = 1'b0;
      end
      #10 rel = 1'b1;
      #30 o_scl = 1'b1;
      #20 ack = !o_sda;  // sampled mid-high, well after sync latency
      #20 o_scl = 1'b0;
      #10 rel = 1'b0;
      #30 o_scl = 1'b1;
      #40 rel = 1'b1;
      #40;
   endtask
endmodule

// ===== test_i2c_addressing_and_data_command.sv
// Purpose: self-checking bench for the addressing and data/command block
// Assumes: bench plays avalon master and transmit fifo, model plays remote master
// Notes: byte enables are tied to all lanes
`timescale 1ns/100ps
module test_i2c_addressing_and_data_command;
   import iac_pkg::*;
   logic i_clock, i_resetn, i_avs_read, i_avs_write, i_tx_ready, i_rx_valid, ack, pop;
   logic [31:0] i_avs_address, i_avs_writedata, q;
   logic [7:0] i_rx_byte;
   logic [31:0] o_avs_readdata;
   logic [8:0] o_tx_data;
   logic [7:0] o_addr_first, o_addr_second;
   logic o_avs_waitrequest, o_tx_valid, o_rx_pop, o_sda, o_sda_oe, o_addr_two;
   logic o_interface_enable, o_transmit_abort, o_read_request;
   wire logic scl, sda;
   int bad_count, cmp_count;
   iac_top DUT (.i_clock, .i_resetn, .i_avs_address, .i_avs_read, .i_avs_write,
      .i_avs_writedata, .i_avs_byteenable(4'hF), .o_avs_readdata, .o_avs_waitrequest,
      .o_tx_valid, .o_tx_data, .i_tx_ready, .i_rx_valid, .i_rx_byte, .o_rx_pop,
      .i_scl(scl), .i_sda(sda), .o_sda, .o_sda_oe, .o_addr_first, .o_addr_second,
      .o_addr_two, .o_interface_enable, .o_transmit_abort, .o_read_request);
   iac_link_model PM (.i_sda_oe(o_sda_oe), .o_scl(scl), .o_sda(sda));
   // 200 MHz core clock
   initial begin
      i_clock = 1'b0;
      forever #2.5 i_clock = !i_clock;
   end
   task automatic conclude;
      $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // one avalon transfer; held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clock);
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_write <= w;
      i_avs_read <= !w;
      do begin
         @(posedge i_clock);
         n++;
      end while (o_avs_waitrequest !== 1'b0 && n < 200);
      if (n >= 200) begin
         bad_count++;
         conclude();
      end
      q = o_avs_readdata;
      pop = o_rx_pop;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
   endtask
   task automatic settle;
      repeat (2) @(posedge i_clock);
   endtask
   task automatic stat(input logic [31:0] e);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("status", e, q & 32'h0000_0070);
   endtask
   // wait for an offered entry, compare, then accept it
   task automatic tx_chk(input logic [8:0] e);
      int n;
      n = 0;
      while (o_tx_valid !== 1'b1 && n < 20) begin
         @(posedge i_clock);
         n++;
      end
      if (n >= 20) begin
         bad_count++;
         conclude();
      end
      chk("tx entry", {23'h0, e}, {23'h0, o_tx_data});
      i_tx_ready <= 1'b1;
      @(posedge i_clock);
      i_tx_ready <= 1'b0;
      settle();
   endtask
   task automatic no_tx;
      settle();
      chk("tx idle", 32'h0, {31'h0, o_tx_valid});
   endtask
   task automatic addr_chk(input logic [31:0] t, input logic [7:0] e);
      bus(1'b1, OFS_TARGET, t);
      settle();
      chk("first address", {24'h0, e}, {24'h0, o_addr_first});
   endtask
   task automatic t_reset;
      bus(1'b0, OFS_TARGET, 32'h0);
      chk("target reset", 32'h0000_0055, q);
      bus(1'b0, OFS_OWN, 32'h0);
      chk("own reset", 32'h0000_0055, q);
      bus(1'b0, OFS_DATA, 32'h0);
      chk("data reset", 32'h0000_0000, q);
      chk("sda drive", 32'h0, {31'h0, o_sda});
      bus(1'b0, 32'h5000_1390, 32'h0);
      chk("unmapped", 32'h0000_0000, q);
      chk("wide first", 32'h0000_00F0, {24'h0, o_addr_first});
      chk("wide second", 32'h0000_0055, {24'h0, o_addr_second});
      chk("wide flag", 32'h1, {31'h0, o_addr_two});
   endtask
   task automatic t_master_addr;
      bus(1'b1, OFS_CONTROL, 32'h0000_0008);
      addr_chk(32'h0000_0012, 8'h24);
      addr_chk(32'h0000_0812, 8'h00);
      stat(32'h0000_0010);
      addr_chk(32'h0000_0C12, 8'h01);
      settle();
      chk("start byte kept", 32'h0000_0001, {24'h0, o_addr_first});
      addr_chk(32'h0000_0412, 8'h24);
      bus(1'b1, OFS_CONTROL, 32'h0000_0018);
      addr_chk(32'h0000_012A, 8'hF2);
      chk("wide second", 32'h0000_002A, {24'h0, o_addr_second});
   endtask
   task automatic t_general_call;
      bus(1'b1, OFS_CONTROL, 32'h0000_0008);
      bus(1'b1, OFS_TARGET, 32'h0000_0812);
      bus(1'b1, OFS_DATA, 32'h0000_01AB);
      no_tx();
      stat(32'h0000_0050);
      chk("abort out", 32'h1, {31'h0, o_transmit_abort});
      bus(1'b1, OFS_DATA, 32'h0000_0033);
      tx_chk(9'h033);
      bus(1'b1, OFS_STATUS, 32'h0000_0040);
      stat(32'h0000_0010);
      bus(1'b1, OFS_TARGET, 32'h0000_0012);
      bus(1'b1, OFS_DATA, 32'h0000_01AB);
      tx_chk(9'h100);
      stat(32'h0000_0000);
   endtask
   task automatic t_loopback;
      bus(1'b1, OFS_TARGET, 32'h0000_0055);
      bus(1'b1, OFS_DATA, 32'h0000_0100);
      no_tx();
      stat(32'h0000_0040);
      bus(1'b1, OFS_DATA, 32'h0000_0012);
      tx_chk(9'h012);
      bus(1'b1, OFS_STATUS, 32'h0000_0040);
   endtask
   task automatic t_own_lock;
      bus(1'b1, OFS_OWN, 32'h0000_012A);
      bus(1'b1, OFS_ENABLE, 32'h0000_0001);
      bus(1'b1, OFS_OWN, 32'h0000_00AA);
      bus(1'b0, OFS_OWN, 32'h0);
      chk("own locked", 32'h0000_012A, q);
      chk("enable out", 32'h1, {31'h0, o_interface_enable});
   endtask
   task automatic t_slave;
      bus(1'b1, OFS_CONTROL, 32'h0000_0000);
      PM.frame(8'h54, ack);
      chk("ack match", 32'h1, {31'h0, ack});
      PM.frame(8'h56, ack);
      chk("ack other", 32'h0, {31'h0, ack});
      bus(1'b1, OFS_CONTROL, 32'h0000_0008);
      PM.frame(8'h54, ack);
      chk("ack wide", 32'h0, {31'h0, ack});
      PM.frame(8'hF2, ack);
      chk("ack wide header", 32'h1, {31'h0, ack});
      bus(1'b1, OFS_CONTROL, 32'h0000_0000);
      PM.frame(8'h55, ack);
      chk("ack read", 32'h1, {31'h0, ack});
      stat(32'h0000_0020);
      chk("read request out", 32'h1, {31'h0, o_read_request});
      bus(1'b1, OFS_DATA, 32'h0000_01AB);
      no_tx();
      stat(32'h0000_0060);
      bus(1'b1, OFS_STATUS, 32'h0000_0040);
      bus(1'b1, OFS_DATA, 32'h0000_0077);
      tx_chk(9'h077);
      stat(32'h0000_0000);
   endtask
   task automatic t_rx_read;
      i_rx_valid <= 1'b1;
      i_rx_byte <= 8'h5A;
      settle();
      bus(1'b0, OFS_DATA, 32'h0);
      chk("rx byte", 32'h0000_005A, q);
      chk("rx pop", 32'h1, {31'h0, pop});
      i_rx_valid <= 1'b0;
   endtask
   // reset for 12 cycles, then the scenarios in turn
   initial begin
      i_resetn = 1'b0;
      i_avs_read = 1'b0;
      i_avs_write = 1'b0;
      i_avs_address = 32'h0;
      i_avs_writedata = 32'h0;
      i_tx_ready = 1'b0;
      i_rx_valid = 1'b0;
      i_rx_byte = 8'h00;
      bad_count = 0;
      cmp_count = 0;
      repeat (12) @(posedge i_clock);
      i_resetn <= 1'b1;
      settle();
      t_reset();
      t_master_addr();
      t_general_call();
      t_loopback();
      t_own_lock();
      t_slave();
      t_rx_read();
      conclude();
   end
endmodule
